// ### rtl/cascade_timer.sv
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "cascade_timer_regs.svh"

module cascade_timer (
    // clock and reset
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // ahb-lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire cascade_timer_pkg::htrans_type htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic                         hready,
    input  wire logic [31:0]                  hwdata,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output cascade_timer_pkg::hresp_type      hresp,
    // pins from outside the clock domain
    input  wire logic                         sub_clock,
    input  wire logic                         count_input_pin,
    // timer outputs
    output logic                              pulse_out_pin,
    output logic                              upper_timer_irq
);

    import cascade_timer_pkg::*;

    // bus state
    logic        wr_pend_q;
    logic        rd_wait_q;
    logic [5:0]  addr_q;
    logic [31:0] rdata_q;

    // software registers
    logic [7:0]  lower_timer_ctrl_q;
    logic [7:0]  upper_timer_ctrl_q;
    logic [7:0]  width_reg_low_q;
    logic [7:0]  width_reg_high_q;
    logic [7:0]  period_reg_low_q;
    logic [7:0]  period_reg_high_q;

    // counter and output
    logic [7:0]  cnt_low_q;
    logic [7:0]  cnt_high_q;
    logic [7:0]  cnt_low_d;
    logic [7:0]  cnt_high_d;
    logic        level_q;
    logic        level_d;
    logic        irq_q;
    logic        irq_d;

    // pin synchronisers and edge history
    logic        sub_meta_q;
    logic        sub_sync_q;
    logic        sub_prev_q;
    logic        pin_meta_q;
    logic        pin_sync_q;
    logic        pin_prev_q;

    // register match on a byte offset
    function automatic logic is_reg(input logic [5:0] a, input logic [5:0] ofs);
        return a == ofs;
    endfunction : is_reg

    // address phase decode
    wire         addr_phase = hsel & htrans[1] & hready;
    wire         wr_start   = addr_phase & hwrite;
    wire         rd_start   = addr_phase & ~hwrite;

    // data phase write strobes
    wire         wr_lower   = wr_pend_q & is_reg(addr_q, `OFS_LOWER_CTRL);
    wire         wr_upper   = wr_pend_q & is_reg(addr_q, `OFS_UPPER_CTRL);
    wire         wr_wlow    = wr_pend_q & is_reg(addr_q, `OFS_WIDTH_LOW);
    wire         wr_whigh   = wr_pend_q & is_reg(addr_q, `OFS_WIDTH_HIGH);
    wire         wr_plow    = wr_pend_q & is_reg(addr_q, `OFS_PERIOD_LOW);
    wire         wr_phigh   = wr_pend_q & is_reg(addr_q, `OFS_PERIOD_HIGH);
    wire [7:0]   wbyte      = hwdata[7:0];

    // control fields
    wire         run        = upper_timer_ctrl_q[`UPPER_RUN_BIT];
    wire         start_lvl  = upper_timer_ctrl_q[`UPPER_LEVEL_BIT];
    wire [2:0]   mode_code  = upper_timer_ctrl_q[`MODE_MSB:`MODE_LSB];
    wire [2:0]   clk_sel    = lower_timer_ctrl_q[`CLKSEL_MSB:`CLKSEL_LSB];

    // compare values, read straight from the registers
    wire [15:0]  width_val  = {width_reg_high_q, width_reg_low_q};
    wire [15:0]  period_val = {period_reg_high_q, period_reg_low_q};

    count_mode_type mode;

    always_comb begin
        case (mode_code)
            `MODE_PULSE:  mode = mode_pulse;
            `MODE_WARMUP: mode = mode_warmup;
            default:      mode = mode_idle;
        endcase
    end

    // only the two cascaded modes count here; others leave the counter idle
    wire         active     = run & (mode != mode_idle);

    // synchronised pin edges; only the second stage and its one-cycle delayed copy are looked at
    wire         sub_tick   = sub_sync_q & ~sub_prev_q;
    wire         pin_tick   = ~pin_sync_q & pin_prev_q;
    wire         count_tick;

    cascade_prescaler prescaler (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_sel    (clk_sel),
        .sub_tick   (sub_tick),
        .pin_tick   (pin_tick),
        .count_tick (count_tick)
    );

    // cascade: low byte carry steps the upper byte
    wire         low_carry  = cnt_low_q == 8'hff;
    wire [7:0]   low_inc    = cnt_low_q + 8'h01;
    wire [7:0]   high_inc   = cnt_high_q + {7'h00, low_carry};
    wire [15:0]  cnt_next   = {high_inc, low_inc};

    // match detection on the value about to be reached
    wire         width_hit  = (mode == mode_pulse) & (cnt_next == width_val);
    wire         pulse_end  = (mode == mode_pulse) & (cnt_next == period_val);
    wire         warm_end   = (mode == mode_warmup)
                            & (cnt_next[15:8] == period_reg_high_q)
                            & (cnt_next[7:0] == 8'h00);
    wire         step       = active & count_tick;
    wire         period_hit = step & (pulse_end | warm_end);

    // start level loads only on writes seen while already stopped
    wire         level_load = wr_upper & ~run;

    always_comb begin
        cnt_low_d  = cnt_low_q;
        cnt_high_d = cnt_high_q;
        level_d    = level_q;
        irq_d      = 1'b0;
        if (!active) begin
            cnt_low_d  = `RST_BYTE;
            cnt_high_d = `RST_BYTE;
        end else if (period_hit) begin
            // period match wins over a width match on the same count
            cnt_low_d  = `RST_BYTE;
            cnt_high_d = `RST_BYTE;
            irq_d      = 1'b1;
            if (mode == mode_pulse) begin
                level_d = ~level_q;
            end
        end else if (step) begin
            cnt_low_d  = low_inc;
            cnt_high_d = high_inc;
            if (width_hit) begin
                level_d = ~level_q;
            end
        end
        if (level_load) begin
            level_d = wbyte[`UPPER_LEVEL_BIT];
        end
    end

    // pins cross into hclk through two flip-flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_meta_q <= 1'b0;
            sub_sync_q <= 1'b0;
            sub_prev_q <= 1'b0;
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            sub_meta_q <= sub_clock;
            sub_sync_q <= sub_meta_q;
            sub_prev_q <= sub_sync_q;
            pin_meta_q <= count_input_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // counter, flip-flop and event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_low_q  <= `RST_BYTE;
            cnt_high_q <= `RST_BYTE;
            level_q    <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            cnt_low_q  <= cnt_low_d;
            cnt_high_q <= cnt_high_d;
            level_q    <= level_d;
            irq_q      <= irq_d;
        end
    end

    // bus phase tracking; reads wait one cycle so a prior write is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            addr_q    <= 6'h00;
        end else begin
            wr_pend_q <= wr_start;
            rd_wait_q <= rd_start;
            if (addr_phase) begin
                addr_q <= haddr[5:0];
            end
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lower_timer_ctrl_q <= `RST_BYTE;
            upper_timer_ctrl_q <= `RST_BYTE;
            width_reg_low_q    <= `RST_BYTE;
            width_reg_high_q   <= `RST_BYTE;
            period_reg_low_q   <= `RST_BYTE;
            period_reg_high_q  <= `RST_BYTE;
        end else begin
            if (wr_lower) begin
                lower_timer_ctrl_q <= wbyte;
            end
            if (wr_upper) begin
                upper_timer_ctrl_q <= wbyte;
            end
            if (wr_wlow) begin
                width_reg_low_q <= wbyte;
            end
            if (wr_whigh) begin
                width_reg_high_q <= wbyte;
            end
            if (wr_plow) begin
                period_reg_low_q <= wbyte;
            end
            if (wr_phigh) begin
                period_reg_high_q <= wbyte;
            end
        end
    end

    // read mux; unmapped offsets read zero
    wire [7:0] status_byte = {6'h00, run, level_q};
    logic [7:0] rd_byte;

    always_comb begin
        case (addr_q)
            `OFS_LOWER_CTRL:  rd_byte = lower_timer_ctrl_q;
            `OFS_UPPER_CTRL:  rd_byte = upper_timer_ctrl_q;
            `OFS_WIDTH_LOW:   rd_byte = width_reg_low_q;
            `OFS_WIDTH_HIGH:  rd_byte = width_reg_high_q;
            `OFS_PERIOD_LOW:  rd_byte = period_reg_low_q;
            `OFS_PERIOD_HIGH: rd_byte = period_reg_high_q;
            `OFS_STATUS:      rd_byte = status_byte;
            `OFS_COUNT_LOW:   rd_byte = cnt_low_q;
            `OFS_COUNT_HIGH:  rd_byte = cnt_high_q;
            default:          rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_wait_q) begin
            rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // outputs
    assign hrdata          = rdata_q;
    assign hreadyout       = ~rd_wait_q;
    assign hresp           = 2'h0;
    // while stopped the pin moves only on upper control writes, which load the start level
    assign pulse_out_pin   = ~level_q;
    assign upper_timer_irq = irq_q;

endmodule : cascade_timer

// ### rtl/cascade_timer_regs.svh
`ifndef CASCADE_TIMER_REGS_SVH
`define CASCADE_TIMER_REGS_SVH

// byte offsets on the register bus, one word each
`define OFS_LOWER_CTRL      6'h00
`define OFS_UPPER_CTRL      6'h04
`define OFS_WIDTH_LOW       6'h08
`define OFS_WIDTH_HIGH      6'h0c
`define OFS_PERIOD_LOW      6'h10
`define OFS_PERIOD_HIGH     6'h14
`define OFS_STATUS          6'h18
`define OFS_COUNT_LOW       6'h1c
`define OFS_COUNT_HIGH      6'h20

// field positions
`define UPPER_RUN_BIT       3
`define UPPER_LEVEL_BIT     7
`define MODE_LSB            0
`define MODE_MSB            2
`define CLKSEL_LSB          4
`define CLKSEL_MSB          6
`define STATUS_LEVEL_BIT    0
`define STATUS_RUN_BIT      1

// upper control mode field
`define MODE_PULSE          3'h7
`define MODE_WARMUP         3'h5

// lower control clock select field
`define CLK_DIV11           3'h0
`define CLK_DIV7            3'h1
`define CLK_DIV5            3'h2
`define CLK_DIV3            3'h3
`define CLK_SUB             3'h4
`define CLK_DIV1            3'h5
`define CLK_FULL            3'h6
`define CLK_PIN             3'h7

// reset values and prescaler width
`define RST_BYTE            8'h00
`define RST_COUNT           16'h0000
`define PRESCALE_WIDTH      11

`endif

// ### rtl/cascade_timer_pkg.sv
package cascade_timer_pkg;

    typedef logic [1:0] htrans_type;
    typedef logic [1:0] hresp_type;

    typedef enum logic [1:0] {
        mode_idle,
        mode_pulse,
        mode_warmup
    } count_mode_type;

endpackage : cascade_timer_pkg

// ### rtl/cascade_prescaler.sv
`timescale 1ns/100ps
`include "cascade_timer_regs.svh"

module cascade_prescaler (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // source choice and external events
    input  wire logic [2:0] clk_sel,
    input  wire logic       sub_tick,
    input  wire logic       pin_tick,
    // counting enable
    output logic            count_tick
);

    logic [`PRESCALE_WIDTH-1:0] div_q;
    logic [`PRESCALE_WIDTH-1:0] div_d;

    // one pulse every 2^n cycles of hclk
    function automatic logic low_ones(input logic [`PRESCALE_WIDTH-1:0] v, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < n; i++) begin
            r = r & v[i];
        end
        return r;
    endfunction : low_ones

    assign div_d = div_q + `PRESCALE_WIDTH'(1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    always_comb begin
        case (clk_sel)
            `CLK_DIV11: count_tick = low_ones(div_q, 11);
            `CLK_DIV7:  count_tick = low_ones(div_q, 7);
            `CLK_DIV5:  count_tick = low_ones(div_q, 5);
            `CLK_DIV3:  count_tick = low_ones(div_q, 3);
            `CLK_SUB:   count_tick = sub_tick;
            `CLK_DIV1:  count_tick = div_q[0];
            `CLK_FULL:  count_tick = 1'b1;
            `CLK_PIN:   count_tick = pin_tick;
            default:    count_tick = 1'b0;
        endcase
    end

endmodule : cascade_prescaler

// ### verification/cascade_timer_checker.sv
`timescale 1ns/100ps
`include "cascade_timer_regs.svh"

module cascade_timer_checker (
    // clock and reset
    input wire logic                          hclk,
    input wire logic                          hresetn,
    // bus
    input wire logic                          hsel,
    input wire logic [31:0]                   haddr,
    input wire cascade_timer_pkg::htrans_type htrans,
    input wire logic                          hwrite,
    input wire logic                          hready,
    input wire logic [31:0]                   hwdata,
    input wire logic                          hreadyout,
    // timer outputs
    input wire logic                          pulse_out_pin,
    input wire logic                          upper_timer_irq
);
    import cascade_timer_pkg::*;
    logic       upw_q;
    logic [7:0] ctrl_q;
    wire        taken = hsel & htrans[1] & hready;
    wire        run   = ctrl_q[`UPPER_RUN_BIT];
    wire        pulse = ctrl_q[2:0] == `MODE_PULSE;
    wire        warm  = ctrl_q[2:0] == `MODE_WARMUP;
    wire        mode_ok = pulse | warm;

    // shadow of the upper control byte, so mode and run are known here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upw_q  <= 1'b0;
            ctrl_q <= 8'h00;
        end else begin
            if (hready)
                upw_q <= taken & hwrite & (haddr[5:0] == `OFS_UPPER_CTRL);
            if (upw_q)
                ctrl_q <= hwdata[7:0];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_PIN_HIGH_AFTER_RESET: assert property ($rose(hresetn) |-> pulse_out_pin)
        else $error("pulse pin low after reset");
    AST_IRQ_ONE_CYCLE: assert property (upper_timer_irq |=> !upper_timer_irq)
        else $error("irq longer than one cycle");
    AST_IRQ_NEEDS_RUN: assert property (upper_timer_irq |-> $past(run) || $past(run, 2))
        else $error("irq while stopped");
    AST_IRQ_NEEDS_MODE: assert property (upper_timer_irq |-> $past(mode_ok, 2))
        else $error("irq outside counting modes");
    AST_PULSE_IRQ_TOGGLED: assert property (upper_timer_irq && $past(pulse) |->
        pulse_out_pin != $past(pulse_out_pin) ||
        $past(pulse_out_pin) != $past(pulse_out_pin, 2) ||
        $past(pulse_out_pin, 2) != $past(pulse_out_pin, 3))
        else $error("period end without pin toggle");
    // pin may trail a stop or a control write by two cycles
    AST_STOPPED_PIN_HOLDS: assert property (!$past(run) && !$past(run, 2) &&
        !$past(upw_q) && !$past(upw_q, 2) |-> $stable(pulse_out_pin))
        else $error("pin moved while stopped");
    AST_WARMUP_PIN_STILL: assert property (warm && $past(run) && $past(run, 2) &&
        !$past(upw_q) && !$past(upw_q, 2) |-> $stable(pulse_out_pin))
        else $error("pin moved in warm-up");
    AST_READ_ONE_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not one cycle");

    COV_PULSE_IRQ: cover property (upper_timer_irq && pulse);
    COV_WARM_IRQ: cover property (upper_timer_irq && warm);
    COV_STOP: cover property ($fell(run));
endmodule : cascade_timer_checker

bind cascade_timer cascade_timer_checker cascade_timer_checker_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .pulse_out_pin(pulse_out_pin), .upper_timer_irq(upper_timer_irq));

// ### verification/cascaded_timer_pulse_warmup_tb_top.sv
`timescale 1ns/100ps
`include "cascade_timer_regs.svh"

module cascaded_timer_pulse_warmup_tb_top;
    import cascade_timer_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, sub_clock, count_input_pin;
    logic        hreadyout, pulse_out_pin, upper_timer_irq, rdy_n;
    logic [31:0] haddr, hwdata, hrdata, rd_n;
    logic [2:0]  hsize, sub_cnt;
    htrans_type  htrans;
    hresp_type   hresp;
    int          mismatches, samples_checked;

    cascade_timer cascade_timer_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sub_clock(sub_clock),
        .count_input_pin(count_input_pin), .pulse_out_pin(pulse_out_pin),
        .upper_timer_irq(upper_timer_irq));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // values as they stood just before the next rising edge
    always @(negedge hclk) begin
        rdy_n = hreadyout;
        rd_n  = hrdata;
    end

    // sub oscillator: one rising edge every 8 bus cycles
    always @(posedge hclk) begin
        sub_cnt   <= sub_cnt + 3'h1;
        sub_clock <= sub_cnt[2];
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic xfer(input logic [5:0] a, input logic wr_en, input logic [7:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {26'h0, a};
        hwrite <= wr_en;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (rdy_n !== 1'b1 && n < 16);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do begin
            @(posedge hclk);
            n++;
        end while (rdy_n !== 1'b1 && n < 32);
        q = rd_n;
        if (n >= 32)
            mismatches++;
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic gap(output int n, output int lo);
        n = 0;
        lo = 0;
        do begin
            @(negedge hclk);
            n++;
            lo += (pulse_out_pin === 1'b0);
        end while (upper_timer_irq !== 1'b1 && n < 9000);
    endtask : gap

    task automatic t_reset;
        logic [31:0] q;
        check("pin after reset", pulse_out_pin, 32'h1);
        check("irq after reset", upper_timer_irq, 32'h0);
        check("hresp okay", {30'h0, hresp}, 32'h0);
        wr(`OFS_COUNT_LOW, 8'h5a);
        wr(6'h3c, 8'hff);
        for (int i = 0; i < 16; i++) begin
            xfer(6'(i * 4), 1'b0, 8'h00, q);
            check("reset value", q, 32'h0);
        end
    endtask : t_reset

    task automatic pulse_run(input logic [7:0] lc, input logic [15:0] w, p, input int div);
        int n, lo;
        wr(`OFS_LOWER_CTRL, lc);
        wr(`OFS_WIDTH_LOW, w[7:0]);
        wr(`OFS_WIDTH_HIGH, w[15:8]);
        wr(`OFS_PERIOD_LOW, p[7:0]);
        wr(`OFS_PERIOD_HIGH, p[15:8]);
        wr(`OFS_UPPER_CTRL, 8'h57);
        wr(`OFS_UPPER_CTRL, 8'h5f);
        gap(n, lo);
        gap(n, lo);
        check("pulse period", n, p * div);
        check("pulse low", lo, (p - w) * div);
    endtask : pulse_run

    task automatic t_retune;
        int n, lo;
        wr(`OFS_PERIOD_LOW, 8'h07);
        gap(n, lo);
        gap(n, lo);
        check("new period", n, 32'd7);
    endtask : t_retune

    task automatic t_stop;
        logic [31:0] q;
        logic        pin;
        wr(`OFS_UPPER_CTRL, 8'h57);
        repeat (3) @(negedge hclk);
        pin = pulse_out_pin;
        repeat (20) @(negedge hclk);
        check("held pin", pulse_out_pin, pin);
        xfer(`OFS_STATUS, 1'b0, 8'h00, q);
        check("status", q, {31'h0, ~pin});
        xfer(`OFS_COUNT_LOW, 1'b0, 8'h00, q);
        check("count stopped", q, 32'h0);
        wr(`OFS_UPPER_CTRL, 8'hd7);
        repeat (2) @(negedge hclk);
        check("pin level one", pulse_out_pin, 32'h0);
        wr(`OFS_UPPER_CTRL, 8'h57);
        repeat (2) @(negedge hclk);
        check("pin forced high", pulse_out_pin, 32'h1);
    endtask : t_stop

    task automatic t_warm;
        int n, lo;
        wr(`OFS_LOWER_CTRL, 8'h43);
        wr(`OFS_UPPER_CTRL, 8'h05);
        wr(`OFS_PERIOD_LOW, 8'h77);
        wr(`OFS_PERIOD_HIGH, 8'h01);
        wr(`OFS_UPPER_CTRL, 8'h0d);
        gap(n, lo);
        gap(n, lo);
        check("warm-up gap", n, 32'd2048);
        check("warm-up pin", lo, 32'h0);
        wr(`OFS_UPPER_CTRL, 8'h05);
    endtask : t_warm

    task automatic t_event;
        int          n, lo;
        logic [31:0] q;
        wr(`OFS_LOWER_CTRL, 8'h73);
        wr(`OFS_WIDTH_LOW, 8'hf0);
        wr(`OFS_PERIOD_LOW, 8'h03);
        wr(`OFS_PERIOD_HIGH, 8'h00);
        wr(`OFS_UPPER_CTRL, 8'h5f);
        // each level held well past two cycles
        repeat (2) begin
            repeat (6) @(posedge hclk);
            count_input_pin <= 1'b0;
            repeat (6) @(posedge hclk);
            count_input_pin <= 1'b1;
        end
        xfer(`OFS_COUNT_LOW, 1'b0, 8'h00, q);
        check("event count", q, 32'h2);
        repeat (6) @(posedge hclk);
        count_input_pin <= 1'b0;
        gap(n, lo);
        check("event irq", n < 20, 32'h1);
        wr(`OFS_UPPER_CTRL, 8'h57);
    endtask : t_event

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        hsize = 3'h2;
        sub_cnt = 3'h0;
        sub_clock = 1'b0;
        count_input_pin = 1'b1;
        mismatches = 0;
        samples_checked = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        t_reset();
        pulse_run(8'h63, 16'h0003, 16'h0005, 1);
        t_retune();
        t_stop();
        pulse_run(8'h33, 16'h0100, 16'h0105, 8);
        t_stop();
        t_warm();
        t_event();
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge hclk);
        mismatches++;
        wrap_up();
    end
endmodule : cascaded_timer_pulse_warmup_tb_top
